// ==== rtl/nmt_pdo_pkg.sv ====
/*
  Shared types and constants for the network-state and process-object scheduler.
  Assumes a 100 MHz core clock and a frame layer that decodes commands into pulses.
*/
package nmt_pdo_pkg;

  // ****************************************
  // Clock and time bases
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int INHIBIT_UNIT_US = 100;
  localparam int EVENT_UNIT_US = 1000;
  localparam int INHIBIT_UNIT_CYC = INHIBIT_UNIT_US * CLK_MHZ;
  localparam int EVENT_UNIT_CYC = EVENT_UNIT_US * CLK_MHZ;
  localparam int INIT_CYC = 4;

  // ****************************************
  // Transmission-type codes
  // ****************************************
  localparam logic [7:0] TT_ACYC_SYNC = 8'h00;
  localparam logic [7:0] TT_CYC_MAX = 8'hF0;
  localparam logic [7:0] TT_RSV_LO = 8'hF1;
  localparam logic [7:0] TT_RSV_HI = 8'hFB;
  localparam logic [7:0] TT_RTR_SYNC = 8'hFC;
  localparam logic [7:0] TT_RTR_ONLY = 8'hFD;
  localparam logic [7:0] TT_COS_A = 8'hFE;
  localparam logic [7:0] TT_RESET = 8'hFF;

  localparam int IN_W = 16;

  // ****************************************
  // Network states (Gray along boot path)
  // ****************************************
  typedef enum logic [2:0] {
    ST_RST_APP = 3'b000,
    ST_RST_COM = 3'b001,
    ST_INIT = 3'b011,
    ST_PREOP = 3'b010,
    ST_OPER = 3'b110,
    ST_STOP = 3'b111
  } nmt_state_e;

  typedef struct packed {
    logic start;
    logic stop;
    logic preop;
    logic resetNode;
    logic resetComm;
  } nmt_cmd_s;

  typedef struct packed {
    logic we;
    logic [7:0] transType;
    logic [15:0] inhibit;
    logic [15:0] eventTime;
  } pdo_cfg_s;

  typedef struct packed {
    logic valid;
    logic hiPrio;
    logic [IN_W-1:0] data;
    logic [IN_W-1:0] changed;
  } tpdo_s;

  function automatic logic is_reserved(input logic [7:0] t);
    return (t >= TT_RSV_LO) && (t <= TT_RSV_HI);
  endfunction : is_reserved

endpackage : nmt_pdo_pkg

// ==== rtl/unit_timer.sv ====
/*
  Down counter in units of a fixed cycle count; flags expiry.
  Assumes load and count come from one clock domain.
*/
`timescale 1ns/1ps
module unit_timer import nmt_pdo_pkg::*; #(
  parameter int UNIT_CYC = 100
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [15:0] units,
  output logic running
);
  logic [31:0] pre_q;
  logic [15:0] cnt_q;

  always_ff @(posedge core_clk) begin
    if (rst || load) begin
      pre_q <= '0;
      cnt_q <= rst ? 16'h0000 : units;
    end else if (cnt_q != 16'h0000) begin
      if (pre_q == 32'(UNIT_CYC - 1)) begin
        pre_q <= '0;
        cnt_q <= cnt_q - 16'h0001;
      end else begin
        pre_q <= pre_q + 32'h1;
      end
    end
  end

  assign running = (cnt_q != 16'h0000);
endmodule : unit_timer

// ==== rtl/nmt_pdo_scheduler.sv ====
/*
  Network-management state machine and one transmit/receive process-object scheduler.
  Assumes commands, SYNC and remote requests arrive as one-cycle pulses from a frame layer.
*/
`timescale 1ns/1ps
module nmt_pdo_scheduler import nmt_pdo_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire nmt_cmd_s nmtCmd,
  input wire logic syncRx,
  input wire logic rtrRx,
  input wire pdo_cfg_s cfg,
  input wire logic [IN_W-1:0] inputs,
  input wire logic rpdoValid,
  input wire logic [IN_W-1:0] rpdoData,
  input wire logic sdoReq,
  output nmt_state_e state_q,
  output logic bootUp_q,
  output logic cfgReject_q,
  output logic sdoAllow_q,
  output logic [7:0] transType_q,
  output tpdo_s tpdo_q,
  output logic [IN_W-1:0] outputs_q
);
  nmt_state_e state_d;
  logic [2:0] initCnt_q;
  logic [IN_W-1:0] pending_q, sampled_q, lastIn_q;
  logic [7:0] syncCnt_q;
  logic [15:0] inhibit_q, eventTime_q;
  logic eventPend_q, rxHave_q;
  logic inhRun, evtRun, evtRunDly_q, evtExpire, sendNow, isEvt, oper, cfgOk;
  logic [IN_W-1:0] delta;
  logic cosPend_q;
  logic [IN_W-1:0] cosMask_q;

  // ****************************************
  // Network state machine
  // ****************************************
  assign oper = (state_q == ST_OPER);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RST_APP: state_d = ST_RST_COM;
      ST_RST_COM: if (initCnt_q == 3'(INIT_CYC - 1)) state_d = ST_INIT;
      ST_INIT: state_d = ST_PREOP;
      ST_PREOP, ST_OPER, ST_STOP: begin
        if (nmtCmd.resetNode) state_d = ST_RST_APP;
        else if (nmtCmd.resetComm) state_d = ST_RST_COM;
        else if (nmtCmd.stop && state_q != ST_STOP) state_d = ST_STOP;
        else if (nmtCmd.start && state_q != ST_OPER) state_d = ST_OPER;
        else if (nmtCmd.preop && state_q != ST_PREOP) state_d = ST_PREOP;
      end
      default: state_d = ST_RST_APP;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) state_q <= ST_RST_APP;
    else state_q <= state_d;
  end

  always_ff @(posedge core_clk) begin
    if (rst || state_q != ST_RST_COM) initCnt_q <= 3'h0;
    else initCnt_q <= initCnt_q + 3'h1;
  end

  // Boot-up is a single pulse on leaving init
  always_ff @(posedge core_clk) begin
    if (rst) bootUp_q <= 1'b0;
    else bootUp_q <= (state_q == ST_INIT);
  end

  // SDO served in pre-operational and operational only
  always_ff @(posedge core_clk) begin
    if (rst) sdoAllow_q <= 1'b0;
    else sdoAllow_q <= sdoReq && (state_q == ST_PREOP || oper);
  end

  // ****************************************
  // Configuration
  // ****************************************
  // Master is expected to hold pre-operational while writing; we enforce it
  assign cfgOk = cfg.we && (state_q == ST_PREOP) && !is_reserved(cfg.transType);

  always_ff @(posedge core_clk) begin
    // Both reset states restore the communication settings
    if (rst || state_q == ST_RST_APP || state_q == ST_RST_COM) begin
      transType_q <= TT_RESET;
      inhibit_q <= 16'h0000;
      eventTime_q <= 16'h0000;
    end else if (cfgOk) begin
      transType_q <= cfg.transType;
      inhibit_q <= cfg.inhibit;
      eventTime_q <= cfg.eventTime;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) cfgReject_q <= 1'b0;
    else cfgReject_q <= cfg.we && !cfgOk;
  end

  // ****************************************
  // SYNC sampling and receive side
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxHave_q <= 1'b0;
      pending_q <= '0;
      outputs_q <= '0;
    end else if (!oper) begin
      rxHave_q <= 1'b0;
    end else begin
      if (rpdoValid) begin
        pending_q <= rpdoData;
        rxHave_q <= 1'b1;
      end
      if (syncRx && rxHave_q) begin
        outputs_q <= pending_q;
        if (!rpdoValid) rxHave_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) sampled_q <= '0;
    else if (syncRx || (rtrRx && transType_q == TT_RTR_ONLY)) sampled_q <= inputs;
  end

  always_ff @(posedge core_clk) begin
    if (rst) lastIn_q <= '0;
    else lastIn_q <= inputs;
  end
  assign delta = inputs ^ lastIn_q;

  // ****************************************
  // Transmit scheduling
  // ****************************************
  assign isEvt = (transType_q >= TT_COS_A);

  always_ff @(posedge core_clk) begin
    if (rst || !oper) eventPend_q <= 1'b0;
    else if (delta != '0) eventPend_q <= 1'b1;
    else if (syncRx && transType_q == TT_ACYC_SYNC) eventPend_q <= 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (rst || !oper) syncCnt_q <= 8'h00;
    else if (syncRx) syncCnt_q <= (syncCnt_q + 8'h01 >= transType_q) ? 8'h00 : syncCnt_q + 8'h01;
  end

  always_ff @(posedge core_clk) begin
    if (rst) evtRunDly_q <= 1'b0;
    else evtRunDly_q <= evtRun;
  end
  assign evtExpire = evtRunDly_q && !evtRun && eventTime_q != 16'h0000;

  // Change seen under inhibit is held back, not lost; sent when the gap ends
  always_ff @(posedge core_clk) begin
    if (rst || !oper || !isEvt || sendNow) begin
      cosPend_q <= 1'b0;
      cosMask_q <= '0;
    end else if (delta != '0) begin
      cosPend_q <= 1'b1;
      cosMask_q <= cosMask_q | delta;
    end
  end

  always_comb begin
    sendNow = 1'b0;
    if (transType_q == TT_ACYC_SYNC) sendNow = syncRx && (eventPend_q || delta != '0);
    else if (transType_q <= TT_CYC_MAX)
      sendNow = syncRx && (syncCnt_q + 8'h01 >= transType_q);
    else if (transType_q == TT_RTR_SYNC || transType_q == TT_RTR_ONLY) sendNow = rtrRx;
    else if (isEvt) sendNow = !inhRun && (delta != '0 || cosPend_q || evtExpire);
    sendNow = sendNow && oper;
  end

  unit_timer #(.UNIT_CYC(INHIBIT_UNIT_CYC)) inhibitTimer (
    .core_clk(core_clk),
    .rst(rst || !oper),
    .load(sendNow && isEvt),
    .units(inhibit_q),
    .running(inhRun)
  );

  unit_timer #(.UNIT_CYC(EVENT_UNIT_CYC)) eventTimer (
    .core_clk(core_clk),
    .rst(rst || !oper),
    .load((sendNow || (evtExpire && inhRun) || !evtRun) && isEvt && !evtRunDly_q || sendNow),
    .units(eventTime_q),
    .running(evtRun)
  );

  always_ff @(posedge core_clk) begin
    if (rst) tpdo_q <= '0;
    else begin
      tpdo_q.valid <= sendNow;
      tpdo_q.hiPrio <= sendNow && isEvt;
      // Sync types send what this SYNC samples; only type 252 replays an older sample
      tpdo_q.data <= (transType_q == TT_RTR_SYNC) ? sampled_q : inputs;
      tpdo_q.changed <= isEvt ? (delta | cosMask_q) : {IN_W{1'b1}};
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  stop_enter_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ST_PREOP || state_q == ST_OPER) && nmtCmd.stop && !nmtCmd.resetNode
      && !nmtCmd.resetComm |=> state_q == ST_STOP) else $error("stop not entered");
  start_enter_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == ST_PREOP || state_q == ST_STOP) && nmtCmd.start && !nmtCmd.stop
      && !nmtCmd.resetNode && !nmtCmd.resetComm |=> oper) else $error("start not entered");
  boot_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
    bootUp_q |-> state_q == ST_PREOP && !$past(bootUp_q)) else $error("boot-up wrong");
  pdo_oper_a: assert property (@(posedge core_clk) disable iff (rst)
    tpdo_q.valid |-> $past(oper)) else $error("pdo outside operational");
  sdo_stop_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(state_q) == ST_STOP |-> !sdoAllow_q) else $error("sdo in stopped");
  rsv_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    cfg.we && is_reserved(cfg.transType) && state_q != ST_RST_APP && state_q != ST_RST_COM
      |=> $stable(transType_q))
    else $error("reserved type taken");
  rtr_only_a: assert property (@(posedge core_clk) disable iff (rst)
    tpdo_q.valid && $past(transType_q) >= TT_RTR_SYNC && $past(transType_q) <= TT_RTR_ONLY
      |-> $past(rtrRx)) else $error("rtr type sent unasked");
  evt_off_a: assert property (@(posedge core_clk) disable iff (rst)
    tpdo_q.valid && $past(isEvt) && $past(eventTime_q) == 16'h0000
      |-> $past(delta) != '0 || $past(cosPend_q)) else $error("event send without change");
  sequence resetSeq;
    (state_q == ST_RST_APP) ##1 (state_q == ST_RST_COM) [*4] ##1 (state_q == ST_INIT);
  endsequence
  reset_path_a: assert property (@(posedge core_clk) disable iff (rst)
    nmtCmd.resetNode && state_q == ST_PREOP |=> resetSeq ##1 state_q == ST_PREOP)
    else $error("reset path wrong");
endmodule : nmt_pdo_scheduler

// ==== sim/can_master_model.sv ====
/*
  Bus master model: issues NMT, SYNC, remote, config, SDO and receive-object pulses.
  Assumes the bench calls pulse() and that every pulse lasts one core_clk cycle.
*/
`timescale 1ns/1ps
module can_master_model import nmt_pdo_pkg::*; (
  input wire logic core_clk,
  output nmt_cmd_s nmtCmd,
  output logic syncRx,
  output logic rtrRx,
  output pdo_cfg_s cfg,
  output logic rpdoValid,
  output logic [IN_W-1:0] rpdoData,
  output logic sdoReq
);
  initial begin
    nmtCmd = '0;
    syncRx = 1'b0;
    rtrRx = 1'b0;
    cfg = '0;
    rpdoValid = 1'b0;
    rpdoData = 16'h0000;
    sdoReq = 1'b0;
  end

  // ****************************************
  // One request: 0 nmt 1 sync 2 rtr 3 cfg 4 rpdo 5 sdo
  // ****************************************
  task automatic pulse(input int sel, input logic [39:0] arg);
    @(posedge core_clk);
    case (sel)
      0: nmtCmd <= nmt_cmd_s'(arg[4:0]);
      1: syncRx <= 1'b1;
      2: rtrRx <= 1'b1;
      3: cfg <= {1'b1, arg};
      4: begin
        rpdoValid <= 1'b1;
        rpdoData <= arg[IN_W-1:0];
      end
      default: sdoReq <= 1'b1;
    endcase
    @(posedge core_clk);
    nmtCmd <= '0;
    syncRx <= 1'b0;
    rtrRx <= 1'b0;
    sdoReq <= 1'b0;
    rpdoValid <= 1'b0;
    // Released fields show garbage, not the last value
    cfg <= {1'b0, ~cfg[39:0]};
    rpdoData <= ~rpdoData;
  endtask : pulse
endmodule : can_master_model

// ==== sim/nmt_pdo_scheduler_tb.sv ====
/*
  Self-checking bench for the network-state and process-object scheduler.
  Assumes the master model drives the bus side; the bench drives inputs and rst.
*/
`timescale 1ns/1ps
module nmt_pdo_scheduler_tb import nmt_pdo_pkg::*;;
  localparam logic [4:0] C_START = 5'h10;
  localparam logic [4:0] C_STOP = 5'h08;
  localparam logic [4:0] C_PRE = 5'h04;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [IN_W-1:0] inputs = 16'h0000;
  nmt_cmd_s nmtCmd;
  pdo_cfg_s cfg;
  logic syncRx, rtrRx, rpdoValid, sdoReq, bootUp_q, cfgReject_q, sdoAllow_q;
  logic [IN_W-1:0] rpdoData, outputs_q, a, b;
  nmt_state_e state_q, cur;
  logic [7:0] transType_q, curT;
  tpdo_s tpdo_q, lastTx;
  int failures = 0;
  int total_checks = 0;
  int txCount = 0;
  int c0, n;
  logic [4:0] walk [9] = '{C_STOP, C_START, C_PRE, C_START, C_STOP, C_PRE, C_STOP, C_START, C_PRE};

  can_master_model i_master (.core_clk(core_clk), .nmtCmd(nmtCmd), .syncRx(syncRx),
    .rtrRx(rtrRx), .cfg(cfg), .rpdoValid(rpdoValid), .rpdoData(rpdoData), .sdoReq(sdoReq));
  nmt_pdo_scheduler i_dut (.core_clk(core_clk), .rst(rst), .nmtCmd(nmtCmd), .syncRx(syncRx),
    .rtrRx(rtrRx), .cfg(cfg), .inputs(inputs), .rpdoValid(rpdoValid), .rpdoData(rpdoData),
    .sdoReq(sdoReq), .state_q(state_q), .bootUp_q(bootUp_q), .cfgReject_q(cfgReject_q),
    .sdoAllow_q(sdoAllow_q), .transType_q(transType_q), .tpdo_q(tpdo_q), .outputs_q(outputs_q));

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (tpdo_q.valid === 1'b1) begin
      txCount++;
      lastTx = tpdo_q;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [IN_W-1:0] seen, input logic [IN_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  function automatic nmt_state_e next_state(input nmt_state_e s, input logic [4:0] c);
    if (c[1]) return ST_RST_APP;
    if (c[0]) return ST_RST_COM;
    if (c[3] && s != ST_STOP) return ST_STOP;
    if (c[4] && s != ST_OPER) return ST_OPER;
    if (c[2] && s != ST_PREOP) return ST_PREOP;
    return s;
  endfunction : next_state

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic setin(input logic [IN_W-1:0] v);
    @(posedge core_clk);
    inputs <= v;
  endtask : setin

  task automatic nmt(input logic [4:0] c);
    cur = next_state(cur, c);
    i_master.pulse(0, {35'h0, c});
    #1;
    check(IN_W'(state_q), IN_W'(cur));
  endtask : nmt

  task automatic wcfg(input logic [7:0] t, input logic [15:0] inh);
    logic ok;
    ok = (cur == ST_PREOP) && !(t >= 8'hF1 && t <= 8'hFB);
    i_master.pulse(3, {t, inh, 16'h0000});
    #1;
    if (ok) curT = t;
    check(IN_W'(transType_q), IN_W'(curT));
    check(IN_W'(cfgReject_q), IN_W'(!ok));
  endtask : wcfg

  task automatic txc(input int k);
    cyc(5);
    check(IN_W'(txCount - c0), IN_W'(k));
  endtask : txc

  task automatic mode(input logic [7:0] t, input logic [15:0] inh);
    nmt(C_PRE);
    wcfg(t, inh);
    nmt(C_START);
    cyc(4);
    c0 = txCount;
  endtask : mode

  task automatic boot;
    int i;
    for (i = 0; i < 20 && state_q !== ST_PREOP; i++) cyc(1);
    if (i == 20) begin
      failures++;
      end_sim();
    end else begin
      check(IN_W'(bootUp_q), IN_W'(1'b1));
      check(IN_W'(transType_q), IN_W'(8'hFF));
      cur = ST_PREOP;
      curT = 8'hFF;
      cyc(1);
      check(IN_W'(bootUp_q), IN_W'(1'b0));
      $display("done: boot");
    end
  endtask : boot

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(91452));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    boot();
    foreach (walk[i]) begin
      nmt(walk[i]);
      i_master.pulse(5, 40'h0);
      #1;
      check(16'(sdoAllow_q), 16'(cur == ST_PREOP || cur == ST_OPER));
      wcfg(8'h01, 16'h0000);
    end
    $display("done: state walk");
    // Pre-operational blocks both process-object directions
    c0 = txCount;
    a = 16'($urandom);
    setin(a);
    i_master.pulse(4, {24'h0, ~a});
    i_master.pulse(1, 40'h0);
    txc(0);
    check(outputs_q, 16'h0000);
    mode(8'hFE, 16'h0000);
    b = a ^ 16'($urandom | 1);
    setin(b);
    txc(1);
    check(IN_W'(lastTx.hiPrio), IN_W'(1'b1));
    check(lastTx.changed, a ^ b);
    check(lastTx.data, b);
    i_master.pulse(4, {24'h0, ~b});
    i_master.pulse(1, 40'h0);
    #1;
    check(outputs_q, ~b);
    $display("done: change of state");
    mode(8'hFF, 16'h0001);
    setin(~b);
    txc(1);
    setin(b);
    cyc(50);
    txc(1);
    cyc(10100);
    // Change held during the gap goes out once inhibit ends
    txc(2);
    check(lastTx.data, b);
    check(lastTx.changed, 16'hFFFF);
    $display("done: inhibit");
    mode(8'h00, 16'h0000);
    i_master.pulse(1, 40'h0);
    cyc(3);
    c0 = txCount;
    i_master.pulse(1, 40'h0);
    txc(0);
    setin(a);
    i_master.pulse(1, 40'h0);
    txc(1);
    check(lastTx.data, a);
    n = 1 + $urandom % 4;
    mode(8'(n), 16'h0000);
    repeat (2 * n) i_master.pulse(1, 40'h0);
    txc(2);
    mode(8'hFD, 16'h0000);
    setin(b);
    i_master.pulse(1, 40'h0);
    txc(0);
    i_master.pulse(2, 40'h0);
    txc(1);
    check(lastTx.data, b);
    check(IN_W'(lastTx.hiPrio), IN_W'(1'b0));
    mode(8'hFC, 16'h0000);
    i_master.pulse(1, 40'h0);
    setin(a);
    cyc(2);
    i_master.pulse(2, 40'h0);
    txc(1);
    check(lastTx.data, b);
    $display("done: sync and remote modes");
    nmt(C_PRE);
    wcfg(8'hF0, 16'h0000);
    for (int t = 'hF1; t <= 'hFB; t++) wcfg(8'(t), 16'h0000);
    nmt(5'h02);
    boot();
    wcfg(8'h05, 16'h0000);
    nmt(5'h01);
    boot();
    end_sim();
  end
endmodule : nmt_pdo_scheduler_tb
